// >>> src/tdc_calibration.v
/*
  Touch panel calibration block: AHB-Lite register file, sample history and
  averaging, and X/Y dot position computation.
  Assumes the A/D converter runs on clk and answers sample_req with a one-cycle
  sample_valid; pen_down comes from the panel pin, asynchronous to clk.
*/
`timescale 1ns/1ps
`include "tdc_defines.vh"

// Contract
// (R1) X scale register holds X dots per count times 1000, 16-bit RW.
// (R2) Y scale register holds Y dots per count times 1000, 16-bit RW.
// (R3) X dot output comes from X scale, point A X dot and adc.
// (R4) Y dot output comes from Y scale, point A Y dot and adc.
// (R5) No X dot calculation while X scale is zero.
// (R6) No Y dot calculation while Y scale is zero.
// (R7) Averaged X is mean of four values, low three bits cleared.
// (R8) Averaged X feeds the X dot calculation; field D9..D3 only.
// (R9) First X history holds the previous averaged value, same field.
// (R10) Point B Y dot register, 16-bit RW.
// (R11) Point A X adc register, 12 bits, upper four read zero.
// (R12) Point A Y adc register, 12 bits, upper four read zero.
// (R13) Point B X and Y adc registers, 12 bits each, upper zero.
// (R14) Software leaves the four point C registers untouched.
// (R15) Pen-down updates position adc and dot output registers.
// (R16) Sampling interval picked by one-hot byte, 20 ms steps to 160 ms.
// (R17) Each new X sample shifts history, oldest lost, then mean recomputed.
// (R18) Dot offset is scale times adc offset divided by 1000, truncated.
module tdc_calibration #(
  parameter ADDR_W      = 10,
  parameter STEP_CYCLES = `TDC_STEP_CYCLES
) (
  // clock and reset
  input  wire              clk,
  input  wire              resetn,
  // AHB-Lite slave
  input  wire              hsel,
  input  wire [ADDR_W-1:0] haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output wire              hreadyout,
  output wire              hresp,
  output reg  [31:0]       hrdata,
  // panel and converter
  input  wire              pen_down,
  output reg               sample_req,
  input  wire              sample_valid,
  input  wire [11:0]       sample_x,
  input  wire [11:0]       sample_y
);

  // bus state
  reg        wr_pend_q;
  reg        rd_pend_q;
  reg  [7:0] idx_q;
  wire       addr_take;
  wire       wr_en;
  wire [15:0] wdat;

  // software registers
  reg  [7:0]  interval_q;
  reg  [15:0] a_x_dot_q;
  reg  [15:0] a_y_dot_q;
  reg  [15:0] b_y_dot_q;
  reg  [15:0] c_x_dot_q;
  reg  [15:0] c_y_dot_q;
  reg  [11:0] a_x_adc_q;
  reg  [11:0] a_y_adc_q;
  reg  [11:0] b_x_adc_q;
  reg  [11:0] b_y_adc_q;
  reg  [11:0] c_x_adc_q;
  reg  [11:0] c_y_adc_q;
  reg  [15:0] x_scale_q;
  reg  [15:0] y_scale_q;

  // hardware-updated registers
  reg  [11:0] pos_x_adc_q;
  reg  [11:0] pos_y_adc_q;
  reg  [15:0] x_dot_q;
  reg  [15:0] y_dot_q;
  reg  [9:0]  x_avg_q;
  reg  [9:0]  x_hist1_q;
  reg  [9:0]  x_hist2_q;
  reg  [9:0]  x_hist3_q;
  reg  [9:0]  x_hist4_q;

  // sampling control
  reg         pen_meta_q;
  reg         pen_sync_q;
  reg         pen_prev_q;
  reg         avg_stage_q;
  reg         dot_stage_q;
  wire        pen_rise;
  wire        tick;
  wire [11:0] sum4;
  wire [9:0]  mean_d;
  wire [15:0] x_dot_d;
  wire [15:0] y_dot_d;
  wire        x_ok;
  wire        y_ok;

  function [15:0] adc_word;
    input [11:0] v;
    begin
      adc_word = {4'h0, v};
    end
  endfunction

  function [9:0] avg_field;
    input [15:0] v;
    reg [15:0] m;
    begin
      m = v & `TDC_AVG_MASK;
      avg_field = m[9:0];
    end
  endfunction

  // bus: writes take no wait state, reads take one to register hrdata
  assign addr_take = hsel & hready & (htrans == `TDC_HTRANS_NONSEQ);
  assign wr_en     = wr_pend_q;
  assign wdat      = hwdata[15:0];
  assign hreadyout = ~rd_pend_q;
  assign hresp     = `TDC_HRESP_OKAY;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q     <= 8'h00;
    end else begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      if (addr_take) begin
        idx_q     <= haddr[9:2];
        wr_pend_q <= hwrite;
        rd_pend_q <= ~hwrite;
      end
    end
  end

  // read data; unmapped offsets read zero
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend_q) begin
      case (idx_q)
        `TDC_IDX_INTERVAL:  hrdata <= {24'h000000, interval_q};
        `TDC_IDX_POS_X_ADC: hrdata <= {16'h0000, adc_word(pos_x_adc_q)};
        `TDC_IDX_POS_Y_ADC: hrdata <= {16'h0000, adc_word(pos_y_adc_q)};
        `TDC_IDX_X_DOT_OUT: hrdata <= {16'h0000, x_dot_q};
        `TDC_IDX_Y_DOT_OUT: hrdata <= {16'h0000, y_dot_q};
        `TDC_IDX_A_X_DOT:   hrdata <= {16'h0000, a_x_dot_q};
        `TDC_IDX_A_Y_DOT:   hrdata <= {16'h0000, a_y_dot_q};
        `TDC_IDX_B_Y_DOT:   hrdata <= {16'h0000, b_y_dot_q};
        `TDC_IDX_C_X_DOT:   hrdata <= {16'h0000, c_x_dot_q};
        `TDC_IDX_C_Y_DOT:   hrdata <= {16'h0000, c_y_dot_q};
        `TDC_IDX_A_X_ADC:   hrdata <= {16'h0000, adc_word(a_x_adc_q)}; // R11
        `TDC_IDX_A_Y_ADC:   hrdata <= {16'h0000, adc_word(a_y_adc_q)}; // R12
        `TDC_IDX_B_X_ADC:   hrdata <= {16'h0000, adc_word(b_x_adc_q)}; // R13
        `TDC_IDX_B_Y_ADC:   hrdata <= {16'h0000, adc_word(b_y_adc_q)}; // R13
        `TDC_IDX_C_X_ADC:   hrdata <= {16'h0000, adc_word(c_x_adc_q)};
        `TDC_IDX_C_Y_ADC:   hrdata <= {16'h0000, adc_word(c_y_adc_q)};
        `TDC_IDX_X_SCALE:   hrdata <= {16'h0000, x_scale_q};
        `TDC_IDX_Y_SCALE:   hrdata <= {16'h0000, y_scale_q};
        `TDC_IDX_X_AVG:     hrdata <= {22'h000000, x_avg_q}; // R8
        `TDC_IDX_X_HIST1:   hrdata <= {22'h000000, x_hist1_q}; // R9
        `TDC_IDX_X_HIST2:   hrdata <= {22'h000000, x_hist2_q};
        `TDC_IDX_X_HIST3:   hrdata <= {22'h000000, x_hist3_q};
        `TDC_IDX_X_HIST4:   hrdata <= {22'h000000, x_hist4_q};
        default:            hrdata <= 32'h00000000;
      endcase
    end
  end

  // calibration registers, written only by software
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      interval_q <= `TDC_RST_INTERVAL;
      a_x_dot_q  <= `TDC_RST_WORD;
      a_y_dot_q  <= `TDC_RST_WORD;
      b_y_dot_q  <= `TDC_RST_WORD;
      c_x_dot_q  <= `TDC_RST_WORD;
      c_y_dot_q  <= `TDC_RST_WORD;
      a_x_adc_q  <= 12'h000;
      a_y_adc_q  <= 12'h000;
      b_x_adc_q  <= 12'h000;
      b_y_adc_q  <= 12'h000;
      c_x_adc_q  <= 12'h000;
      c_y_adc_q  <= 12'h000;
      x_scale_q  <= `TDC_RST_WORD;
      y_scale_q  <= `TDC_RST_WORD;
    end else if (wr_en) begin
      case (idx_q)
        `TDC_IDX_INTERVAL: interval_q <= wdat[7:0]; // R16
        `TDC_IDX_A_X_DOT:  a_x_dot_q  <= wdat;
        `TDC_IDX_A_Y_DOT:  a_y_dot_q  <= wdat;
        `TDC_IDX_B_Y_DOT:  b_y_dot_q  <= wdat; // R10
        // point C storage kept plain; software is expected to leave it alone
        `TDC_IDX_C_X_DOT:  c_x_dot_q  <= wdat;
        `TDC_IDX_C_Y_DOT:  c_y_dot_q  <= wdat;
        `TDC_IDX_A_X_ADC:  a_x_adc_q  <= wdat[11:0]; // R11
        `TDC_IDX_A_Y_ADC:  a_y_adc_q  <= wdat[11:0]; // R12
        `TDC_IDX_B_X_ADC:  b_x_adc_q  <= wdat[11:0]; // R13
        `TDC_IDX_B_Y_ADC:  b_y_adc_q  <= wdat[11:0]; // R13
        `TDC_IDX_C_X_ADC:  c_x_adc_q  <= wdat[11:0];
        `TDC_IDX_C_Y_ADC:  c_y_adc_q  <= wdat[11:0];
        `TDC_IDX_X_SCALE:  x_scale_q  <= wdat; // R1
        `TDC_IDX_Y_SCALE:  y_scale_q  <= wdat; // R2
        default:           interval_q <= interval_q;
      endcase
    end
  end

  // pen pin synchroniser and edge detect on the second stage only
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pen_meta_q <= 1'b0;
      pen_sync_q <= 1'b0;
      pen_prev_q <= 1'b0;
    end else begin
      pen_meta_q <= pen_down;
      pen_sync_q <= pen_meta_q;
      pen_prev_q <= pen_sync_q;
    end
  end

  assign pen_rise = pen_sync_q & ~pen_prev_q;

  tdc_interval_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_timer (
    .clk          (clk),
    .resetn       (resetn),
    .run          (pen_sync_q),
    .interval_sel (interval_q),
    .tick_q       (tick)
  );

  // first conversion right at pen-down, then one per interval while held
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sample_req <= 1'b0;
    end else begin
      sample_req <= pen_rise | (tick & pen_sync_q); // R15
    end
  end

  // new sample enters with the previous three averages
  assign sum4   = {2'b00, pos_x_adc_q[11:2]} + {2'b00, x_hist1_q}
                + {2'b00, x_hist2_q} + {2'b00, x_hist3_q};
  assign mean_d = {sum4[11:5], 3'b000}; // R7

  tdc_dot_calc u_x_calc (
    .scale (x_scale_q),
    .a_dot (a_x_dot_q),
    .a_adc (a_x_adc_q),
    .adc   ({x_avg_q, 2'b00}),
    .dot   (x_dot_d),
    .ok    (x_ok)
  );

  tdc_dot_calc u_y_calc (
    .scale (y_scale_q),
    .a_dot (a_y_dot_q),
    .a_adc (a_y_adc_q),
    .adc   (pos_y_adc_q),
    .dot   (y_dot_d),
    .ok    (y_ok)
  );

  // pipeline: history shift, then average, then dot outputs
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avg_stage_q <= 1'b0;
      dot_stage_q <= 1'b0;
    end else begin
      avg_stage_q <= sample_valid;
      dot_stage_q <= avg_stage_q;
    end
  end

  // position registers follow every converter answer, requested or not
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pos_x_adc_q <= 12'h000;
      pos_y_adc_q <= 12'h000;
    end else if (sample_valid) begin
      pos_x_adc_q <= sample_x; // R15
      pos_y_adc_q <= sample_y; // R15
    end
  end

  // hardware updates win over a software write in the same cycle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      x_hist1_q <= 10'h000;
      x_hist2_q <= 10'h000;
      x_hist3_q <= 10'h000;
      x_hist4_q <= 10'h000;
    end else if (sample_valid) begin
      x_hist1_q <= x_avg_q; // R9
      x_hist2_q <= x_hist1_q; // R17
      x_hist3_q <= x_hist2_q; // R17
      x_hist4_q <= x_hist3_q; // R17
    end else if (wr_en) begin
      case (idx_q)
        `TDC_IDX_X_HIST1: x_hist1_q <= avg_field(wdat); // R9
        `TDC_IDX_X_HIST2: x_hist2_q <= avg_field(wdat);
        `TDC_IDX_X_HIST3: x_hist3_q <= avg_field(wdat);
        `TDC_IDX_X_HIST4: x_hist4_q <= avg_field(wdat);
        default:          x_hist1_q <= x_hist1_q;
      endcase
    end
  end

  // averaged X value; a fresh average beats a software write
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      x_avg_q <= 10'h000;
    end else if (avg_stage_q) begin
      x_avg_q <= mean_d; // R7
    end else if (wr_en && idx_q == `TDC_IDX_X_AVG) begin
      x_avg_q <= avg_field(wdat); // R8
    end
  end

  // dot outputs keep their last value while a scale is zero
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      x_dot_q <= `TDC_RST_WORD;
      y_dot_q <= `TDC_RST_WORD;
    end else if (dot_stage_q) begin
      if (x_ok) begin // R5
        x_dot_q <= x_dot_d; // R3
      end
      if (y_ok) begin // R6
        y_dot_q <= y_dot_d; // R4
      end
    end
  end

endmodule // tdc_calibration

// >>> src/tdc_defines.vh
/*
  Shared constants of the touch dot calibration block: register indices,
  field masks, reset values and timing figures.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef TDC_DEFINES_VH
`define TDC_DEFINES_VH

// register indices; byte address is four times the index
`define TDC_IDX_INTERVAL   8'h22
`define TDC_IDX_POS_X_ADC  8'h24
`define TDC_IDX_POS_Y_ADC  8'h26
`define TDC_IDX_X_DOT_OUT  8'h28
`define TDC_IDX_Y_DOT_OUT  8'h2A
`define TDC_IDX_A_X_DOT    8'h2C
`define TDC_IDX_A_Y_DOT    8'h2E
`define TDC_IDX_B_Y_DOT    8'h32
`define TDC_IDX_C_X_DOT    8'h34
`define TDC_IDX_C_Y_DOT    8'h36
`define TDC_IDX_A_X_ADC    8'h38
`define TDC_IDX_A_Y_ADC    8'h3A
`define TDC_IDX_B_X_ADC    8'h3C
`define TDC_IDX_B_Y_ADC    8'h3E
`define TDC_IDX_C_X_ADC    8'h40
`define TDC_IDX_C_Y_ADC    8'h42
`define TDC_IDX_X_SCALE    8'h44
`define TDC_IDX_Y_SCALE    8'h46
`define TDC_IDX_X_AVG      8'h48
`define TDC_IDX_X_HIST1    8'h4A
`define TDC_IDX_X_HIST2    8'h4C
`define TDC_IDX_X_HIST3    8'h4E
`define TDC_IDX_X_HIST4    8'h50

// field layouts
`define TDC_ADC_MASK       16'h0FFF
`define TDC_AVG_MASK       16'h03F8
`define TDC_AVG_LSB        3
`define TDC_ADC_W          12
`define TDC_AVG_W          10

// reset values
`define TDC_RST_WORD       16'h0000
`define TDC_RST_INTERVAL   8'h01

// scale factor applied to the dots-per-count figures
`define TDC_SCALE_DIV      30'd1000

// AHB encodings
`define TDC_HTRANS_NONSEQ  2'b10
`define TDC_HRESP_OKAY     1'b0

// timing
`define TDC_CLK_HZ         50000000
`define TDC_STEP_MS        20
`define TDC_STEP_CYCLES    ((`TDC_CLK_HZ / 1000) * `TDC_STEP_MS)

`endif

// >>> src/tdc_dot_calc.v
/*
  Dot position arithmetic: dot = point A dot - scale * (adc - point A adc) / 1000.
  Purely combinational; the caller registers the result and gates it with ok.
*/
`timescale 1ns/1ps
`include "tdc_defines.vh"

module tdc_dot_calc (
  // calibration
  input  wire [15:0] scale,
  input  wire [15:0] a_dot,
  input  wire [11:0] a_adc,
  // sample
  input  wire [11:0] adc,
  // result
  output wire [15:0] dot,
  output wire        ok
);

  wire signed [12:0] diff;
  wire signed [29:0] prod;
  wire signed [29:0] divisor;
  wire signed [29:0] quot;

  assign diff    = $signed({1'b0, adc}) - $signed({1'b0, a_adc});
  assign prod    = $signed({1'b0, scale}) * diff;
  assign divisor = $signed(`TDC_SCALE_DIV);
  // signed division truncates toward zero
  assign quot    = prod / divisor; // R18
  // dots fall as counts rise, since point A has the larger dot value
  assign dot     = a_dot - quot[15:0];
  assign ok      = (scale != 16'h0000);

endmodule // tdc_dot_calc

// >>> src/tdc_interval_timer.v
/*
  Sampling interval timer: emits a one-cycle tick every N steps of 20 ms,
  N chosen by a one-hot select byte.
  Assumes run is a synchronous level; the count restarts while run is low.
*/
`timescale 1ns/1ps
`include "tdc_defines.vh"

module tdc_interval_timer #(
  parameter STEP_CYCLES = `TDC_STEP_CYCLES
) (
  // clock and reset
  input  wire       clk,
  input  wire       resetn,
  // control
  input  wire       run,
  input  wire [7:0] interval_sel,
  // output
  output reg        tick_q
);

  reg  [31:0] base_q;
  reg  [2:0]  step_q;
  wire [2:0]  step_last;
  wire        base_end;

  // lowest set bit wins; an illegal zero byte falls back to one step
  function [2:0] onehot_steps;
    input [7:0] sel;
    integer i;
    begin
      onehot_steps = 3'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        if (sel[i]) begin
          onehot_steps = i[2:0];
        end
      end
    end
  endfunction

  assign step_last = onehot_steps(interval_sel);
  assign base_end  = (base_q == STEP_CYCLES - 1);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      base_q <= 32'h00000000;
      step_q <= 3'h0;
      tick_q <= 1'b0;
    end else if (!run) begin
      base_q <= 32'h00000000;
      step_q <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (base_end) begin
        base_q <= 32'h00000000;
        if (step_q >= step_last) begin // R16
          step_q <= 3'h0;
          tick_q <= 1'b1;
        end else begin
          step_q <= step_q + 3'h1;
        end
      end else begin
        base_q <= base_q + 32'h00000001;
      end
    end
  end

endmodule // tdc_interval_timer

// >>> test/tdc_adc_model.sv
/*
  Model of the touch panel and its position converter.
  Assumes the bench steers pen, sample values and answer latency.
*/
`timescale 1ns/1ps
module tdc_adc_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // bench control
  input  wire logic        pen,
  input  wire logic [11:0] x_val,
  input  wire logic [11:0] y_val,
  input  wire logic [3:0]  lat,
  // block side
  output wire logic        pen_down,
  input  wire logic        sample_req,
  output logic             sample_valid,
  output logic [11:0]      sample_x,
  output logic [11:0]      sample_y
);
  logic       busy_q;
  logic [3:0] cnt_q;

  assign pen_down = pen;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_q       <= 1'b0;
      cnt_q        <= 4'h0;
      sample_valid <= 1'b0;
      sample_x     <= 12'h000;
      sample_y     <= 12'h000;
    end else begin
      sample_valid <= 1'b0;
      // data not held between answers, so stale values never pass
      sample_x     <= ~sample_x;
      sample_y     <= ~sample_y;
      if (sample_req) begin
        busy_q <= 1'b1;
        cnt_q  <= lat;
      end else if (busy_q && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (busy_q) begin
        busy_q       <= 1'b0;
        sample_valid <= 1'b1;
        sample_x     <= x_val;
        sample_y     <= y_val;
      end
    end
  end
endmodule // tdc_adc_model

// >>> test/tdc_calibration_sva.sv
/*
  Checker of the calibration block, bound to its ports.
  Assumes the block is the only slave, so hready equals hreadyout.
*/
`timescale 1ns/1ps
module tdc_calibration_chk #(
  parameter ADDR_W = 10
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  // bus
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [31:0]       hrdata,
  // panel side
  input wire logic              pen_down,
  input wire logic              sample_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic       rd_q;
  logic [7:0] idx_q;
  wire        take = hsel && hready && htrans == 2'b10;
  wire        done = rd_q && hreadyout;

  // read data phase tracked so each word is judged at completion
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_q  <= 1'b0;
      idx_q <= 8'h00;
    end else if (hready) begin
      rd_q  <= take && !hwrite;
      idx_q <= haddr[9:2];
    end
  end

  AST_RESP_OKAY: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  AST_READ_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_REQ_PULSE: assert property (sample_req |=> !sample_req)
    else $error("sample request longer than one cycle");
  AST_PEN_REQ: assert property ($rose(pen_down) |-> ##[1:8] sample_req)
    else $error("no sample after pen down");
  AST_IDLE_QUIET: assert property (!pen_down [*8] |-> !sample_req)
    else $error("sample request without pen");
  AST_ADC_FIELD: assert property (done && idx_q inside {8'h38, 8'h3A, 8'h3C, 8'h3E}
    |-> hrdata[31:12] == 20'h00000)
    else $error("converter field upper bits set");
  AST_AVG_FIELD: assert property (done && idx_q == 8'h48 |-> (hrdata & ~32'h000003F8) == 0)
    else $error("average field bits outside range");
  AST_HIST_FIELD: assert property (done && idx_q == 8'h4A |-> (hrdata & ~32'h000003F8) == 0)
    else $error("history field bits outside range");
  AST_WORD_FIELD: assert property (done && idx_q inside {8'h32, 8'h44, 8'h46}
    |-> hrdata[31:16] == 16'h0000)
    else $error("word register upper bits set");

  cover property (done && idx_q == 8'h28);
  cover property ($rose(pen_down) ##[1:8] sample_req);
  cover property (take && hwrite && haddr[9:2] == 8'h44);
endmodule // tdc_calibration_chk

bind tdc_calibration tdc_calibration_chk #(.ADDR_W(ADDR_W)) tdc_calibration_chk_i (
  .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .pen_down(pen_down), .sample_req(sample_req));

// >>> test/testbench.sv
/*
  Self-checking bench of the calibration block: bus tasks, panel model.
  Assumes a short sampling step so interval counts stay small.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module testbench;
  localparam int STEP = 8;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [9:0]  haddr = 10'h000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic        pen = 1'b0;
  logic [11:0] x_val = 12'h000;
  logic [11:0] y_val = 12'h000;
  logic [3:0]  lat = 4'h0;
  logic [31:0] rd;
  int          n_errors = 0;
  int          n_checks = 0;
  int          n;
  wire         hreadyout, hresp, sample_req, sample_valid, pen_down;
  wire [31:0]  hrdata;
  wire [11:0]  sample_x, sample_y;
  logic [7:0]  t_idx [11] = '{8'h32, 8'h38, 8'h3A, 8'h3C, 8'h3E, 8'h44, 8'h46, 8'h48,
                              8'h4A, 8'h24, 8'h30};
  logic [15:0] t_exp [11] = '{16'hFFFF, 16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h0FFF, 16'hFFFF,
                              16'hFFFF, 16'h03F8, 16'h03F8, 16'h0000, 16'h0000};

  always #10 clk = ~clk;

  tdc_calibration #(.STEP_CYCLES(STEP)) tdc_calibration_i (
    .clk(clk), .resetn(resetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pen_down(pen_down),
    .sample_req(sample_req), .sample_valid(sample_valid), .sample_x(sample_x),
    .sample_y(sample_y));

  tdc_adc_model tdc_adc_model_i (
    .clk(clk), .resetn(resetn), .pen(pen), .x_val(x_val), .y_val(y_val), .lat(lat),
    .pen_down(pen_down), .sample_req(sample_req), .sample_valid(sample_valid),
    .sample_x(sample_x), .sample_y(sample_y));

  task automatic rdy();
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d);
    hwrite <= w;
    haddr  <= {idx, 2'b00};
    htrans <= 2'b10;
    rdy();
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    rdy();
    rd = hrdata;
  endtask

  task automatic chk_rd(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 16'h0000);
    `CHK(rd, exp)
  endtask

  task automatic sample(input logic [11:0] x, input logic [11:0] y, input logic [3:0] l);
    x_val <= x;
    y_val <= y;
    lat   <= l;
    pen   <= 1'b1;
    do @(posedge clk); while (sample_req !== 1'b1);
    // early release keeps the interval timer from adding samples
    pen   <= 1'b0;
    do @(posedge clk); while (sample_valid !== 1'b1);
    repeat (4) @(posedge clk);
  endtask

  task automatic gap();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sample_req !== 1'b1);
  endtask

  task test_done();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    test_done();
  end

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk_rd(8'h22, 16'h0001);
    for (int i = 0; i < 11; i++) begin
      chk_rd(t_idx[i], 16'h0000);
      bus(1'b1, t_idx[i], 16'hFFFF);
      chk_rd(t_idx[i], t_exp[i]);
      bus(1'b1, t_idx[i], 16'h0000);
    end
    $display("test registers done");
    // point C registers stay untouched by every access in this bench
    bus(1'b1, 8'h2C, 16'h01F4);
    bus(1'b1, 8'h2E, 16'h07D0);
    bus(1'b1, 8'h38, 16'h0100);
    bus(1'b1, 8'h3A, 16'h0100);
    sample(12'h800, 12'h300, 4'd5);
    chk_rd(8'h24, 16'h0800);
    chk_rd(8'h26, 16'h0300);
    chk_rd(8'h48, 16'h0080);
    chk_rd(8'h28, 16'h0000);
    chk_rd(8'h2A, 16'h0000);
    $display("test zero scale done");
    bus(1'b1, 8'h44, 16'h03EB);
    bus(1'b1, 8'h46, 16'h09C4);
    sample(12'hC00, 12'h300, 4'd0);
    chk_rd(8'h4A, 16'h0080);
    chk_rd(8'h48, 16'h00E0);
    chk_rd(8'h28, 16'hFF73);
    chk_rd(8'h2A, 16'h02D0);
    $display("test dot position done");
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, 8'h22, 16'h0001 << k);
      chk_rd(8'h22, 16'h0001 << k);
      pen <= 1'b1;
      gap();
      gap();
      gap();
      `CHK(n, (k + 1) * STEP)
      pen <= 1'b0;
      repeat (12) @(posedge clk);
    end
    $display("test interval done");
    test_done();
  end
endmodule // testbench
